// >>> hw/root_hub_status_register.sv
`timescale 1ns/1ps
`default_nettype none
module root_hub_status_register #(
   parameter int NPORT = hub_status_pkg::NPORT
) (
   input wire logic mclk_i,
   input wire logic rstn_i,
   input wire logic [7:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [31:0] rdata_o,
   input wire logic overcurrent_i,
   input wire logic per_port_oc_select_i,
   input wire logic per_port_switch_select_i,
   input wire logic [NPORT:0] port_power_mask_i,
   input wire logic [NPORT:1] set_port_power_i,
   input wire logic [NPORT:1] clear_port_power_i,
   input wire logic [NPORT:1] port_connect_change_i,
   input wire logic bus_suspended_i,
   output logic resume_request_o,
   output logic [NPORT:1] port_power_on_flag_o,
   output logic remote_wakeup_enable_o,
   output logic irq_o
);
   typedef struct packed {
      logic wake_en;
      logic oc_change;
      logic oc_seen;
      logic [NPORT:1] pwr;
      logic [hub_status_pkg::NIRQ-1:0] irq_st;
      logic [hub_status_pkg::NIRQ-1:0] irq_msk;
      logic [31:0] rdata;
      logic resume;
      logic irq;
   } hub_state_t;

   hub_state_t st_q;
   hub_state_t st_d;
   logic oc_sync;
   logic oc_now;
   logic hub_wr;
   logic hub_rd;
   logic resume_cause;
   logic [hub_status_pkg::NIRQ-1:0] irq_events;
   logic [NPORT:1] glob_sel;
   logic [NPORT:1] pp_sel;

   // the overcurrent pin comes from outside the clock domain
   sync_two_flop #(
      .WIDTH(1)
   ) u_oc_sync (
      .mclk_i(mclk_i),
      .rstn_i(rstn_i),
      .async_i(overcurrent_i),
      .sync_o(oc_sync)
   );

   // decode, effective indicator and port selection
   always_comb
   begin
      hub_wr = wr_i && (addr_i == hub_status_pkg::CMD_HUB_WRITE);
      hub_rd = rd_i && (addr_i == hub_status_pkg::CMD_HUB_READ);
      oc_now = per_port_oc_select_i ? 1'b0 : oc_sync;
      resume_cause = st_q.wake_en && bus_suspended_i
         && (|port_connect_change_i);
      irq_events = '0;
      irq_events[hub_status_pkg::IRQ_RESUME] = resume_cause;
      irq_events[hub_status_pkg::IRQ_OC_CHG] = (oc_now != st_q.oc_seen);
      // global commands reach every port in global mode, else unmasked ones
      if (per_port_switch_select_i)
      begin
         glob_sel = ~port_power_mask_i[NPORT:1];
         pp_sel = port_power_mask_i[NPORT:1];
      end
      else
      begin
         glob_sel = '1;
         pp_sel = '0;
      end
   end

   // next state of the whole block
   always_comb
   begin
      st_d = st_q;
      // wake enable: clear wins when both action bits are written
      if (hub_wr && wdata_i[hub_status_pkg::B_WAKE_CLR])
      begin
         st_d.wake_en = 1'b0;
      end
      else if (hub_wr && wdata_i[hub_status_pkg::B_WAKE_EN])
      begin
         st_d.wake_en = 1'b1;
      end
      // change flag: a fresh change beats a clear in the same cycle
      if (hub_wr && wdata_i[hub_status_pkg::B_OC_CHG])
      begin
         st_d.oc_change = 1'b0;
      end
      if (oc_now != st_q.oc_seen)
      begin
         st_d.oc_change = 1'b1;
      end
      st_d.oc_seen = oc_now;
      // global power on then off, off wins on a write of both
      if (hub_wr && wdata_i[hub_status_pkg::B_GPWR_ON])
      begin
         st_d.pwr = st_d.pwr | glob_sel;
      end
      if (hub_wr && wdata_i[hub_status_pkg::B_GPWR_OFF])
      begin
         st_d.pwr = st_d.pwr & ~glob_sel;
      end
      // per-port commands act on masked ports in per-port mode only
      st_d.pwr = st_d.pwr | (set_port_power_i & pp_sel);
      st_d.pwr = st_d.pwr & ~(clear_port_power_i & pp_sel);
      // interrupt status: write one to clear, new event wins
      if (wr_i && (addr_i == hub_status_pkg::CMD_IRQ_ST_WRITE))
      begin
         st_d.irq_st = st_q.irq_st & ~wdata_i[hub_status_pkg::NIRQ-1:0];
      end
      st_d.irq_st = st_d.irq_st | irq_events;
      if (wr_i && (addr_i == hub_status_pkg::CMD_IRQ_MSK_WRITE))
      begin
         st_d.irq_msk = wdata_i[hub_status_pkg::NIRQ-1:0];
      end
      st_d.irq = |(st_d.irq_st & st_d.irq_msk);
      st_d.resume = resume_cause;
      // read data stand for one cycle only
      st_d.rdata = '0;
      if (hub_rd)
      begin
         // local power bits and write-only actions read as zero
         st_d.rdata[hub_status_pkg::B_OC_CHG] = st_q.oc_change;
         st_d.rdata[hub_status_pkg::B_WAKE_EN] = st_q.wake_en;
         st_d.rdata[hub_status_pkg::B_OC] = oc_now;
      end
      else if (rd_i && (addr_i == hub_status_pkg::CMD_IRQ_ST_READ))
      begin
         st_d.rdata[hub_status_pkg::NIRQ-1:0] = st_q.irq_st;
      end
      else if (rd_i && (addr_i == hub_status_pkg::CMD_IRQ_MSK_READ))
      begin
         st_d.rdata[hub_status_pkg::NIRQ-1:0] = st_q.irq_msk;
      end
   end

   // state register
   always_ff @(posedge mclk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         st_q.wake_en <= hub_status_pkg::RST_WAKE_EN;
         st_q.oc_change <= hub_status_pkg::RST_OC_CHG;
         st_q.oc_seen <= 1'b0;
         st_q.pwr <= hub_status_pkg::RST_PWR;
         st_q.irq_st <= hub_status_pkg::RST_IRQ_ST;
         st_q.irq_msk <= hub_status_pkg::RST_IRQ_MSK;
         st_q.rdata <= '0;
         st_q.resume <= 1'b0;
         st_q.irq <= 1'b0;
      end
      else
      begin
         st_q <= st_d;
      end
   end

   // outputs straight from the state flops
   assign rdata_o = st_q.rdata;
   assign resume_request_o = st_q.resume;
   assign port_power_on_flag_o = st_q.pwr;
   assign remote_wakeup_enable_o = st_q.wake_en;
   assign irq_o = st_q.irq;

   // named sequences for the write and wake paths
   sequence seq_hub_write(int b);
      hub_wr && wdata_i[b];
   endsequence

   sequence seq_resume_cause;
      st_q.wake_en && bus_suspended_i && (|port_connect_change_i);
   endsequence

   chk_wake_clear: assert property (
      @(posedge mclk_i) disable iff (!rstn_i)
      seq_hub_write(hub_status_pkg::B_WAKE_CLR) |=> !remote_wakeup_enable_o)
      else $error("wake enable not cleared by bit 31 write");

   chk_wake_set: assert property (
      @(posedge mclk_i) disable iff (!rstn_i)
      seq_hub_write(hub_status_pkg::B_WAKE_EN)
      and !wdata_i[hub_status_pkg::B_WAKE_CLR]
      |=> remote_wakeup_enable_o)
      else $error("wake enable not set by bit 15 write");

   chk_wake_hold: assert property (
      @(posedge mclk_i) disable iff (!rstn_i)
      !(hub_wr && (wdata_i[hub_status_pkg::B_WAKE_CLR]
      || wdata_i[hub_status_pkg::B_WAKE_EN]))
      |=> $stable(remote_wakeup_enable_o))
      else $error("wake enable moved without a write");

   chk_resume_wake: assert property (
      @(posedge mclk_i) disable iff (!rstn_i)
      seq_resume_cause |=> resume_request_o
      && st_q.irq_st[hub_status_pkg::IRQ_RESUME])
      else $error("connect change did not resume");

   chk_no_wake: assert property (
      @(posedge mclk_i) disable iff (!rstn_i)
      !st_q.wake_en |=> !resume_request_o)
      else $error("resume raised while wake disabled");

   chk_oc_change: assert property (
      @(posedge mclk_i) disable iff (!rstn_i)
      (oc_now != st_q.oc_seen) |=> st_q.oc_change)
      else $error("overcurrent change flag not set");

   chk_oc_clear: assert property (
      @(posedge mclk_i) disable iff (!rstn_i)
      seq_hub_write(hub_status_pkg::B_OC_CHG) and (oc_now == st_q.oc_seen)
      |=> !st_q.oc_change)
      else $error("overcurrent change flag not cleared");

   chk_oc_keep: assert property (
      @(posedge mclk_i) disable iff (!rstn_i)
      st_q.oc_change && !(hub_wr && wdata_i[hub_status_pkg::B_OC_CHG])
      |=> st_q.oc_change)
      else $error("overcurrent change flag lost without a clear");

   chk_oc_read: assert property (
      @(posedge mclk_i) disable iff (!rstn_i)
      hub_rd |=> rdata_o[hub_status_pkg::B_OC]
      == ($past(oc_sync) && !$past(per_port_oc_select_i)))
      else $error("overcurrent indicator read wrong");

   chk_oc_perport: assert property (
      @(posedge mclk_i) disable iff (!rstn_i)
      hub_rd && per_port_oc_select_i |=> !rdata_o[hub_status_pkg::B_OC])
      else $error("hub indicator nonzero in per-port mode");

   chk_read_zero: assert property (
      @(posedge mclk_i) disable iff (!rstn_i)
      $past(hub_rd) |-> !rdata_o[hub_status_pkg::B_LP]
      && !rdata_o[hub_status_pkg::B_LP_CHG]
      && !rdata_o[hub_status_pkg::B_WAKE_CLR])
      else $error("local power or action bit read nonzero");

   chk_read_wake: assert property (
      @(posedge mclk_i) disable iff (!rstn_i)
      hub_rd |=> rdata_o[hub_status_pkg::B_WAKE_EN] == $past(st_q.wake_en)
      ##1 rdata_o == '0 || $past(rd_i))
      else $error("wake enable read wrong");

   chk_rdata_idle: assert property (
      @(posedge mclk_i) disable iff (!rstn_i)
      !rd_i |=> rdata_o == '0)
      else $error("read data present without a read");

   chk_global_on: assert property (
      @(posedge mclk_i) disable iff (!rstn_i)
      seq_hub_write(hub_status_pkg::B_GPWR_ON)
      and !wdata_i[hub_status_pkg::B_GPWR_OFF] and !per_port_switch_select_i
      |=> &port_power_on_flag_o)
      else $error("global power on missed a port");

   chk_perport_on: assert property (
      @(posedge mclk_i) disable iff (!rstn_i)
      seq_hub_write(hub_status_pkg::B_GPWR_ON)
      and !wdata_i[hub_status_pkg::B_GPWR_OFF] and per_port_switch_select_i
      and (clear_port_power_i == '0)
      |=> ((port_power_on_flag_o & ~$past(port_power_mask_i[NPORT:1]))
      == ~$past(port_power_mask_i[NPORT:1])))
      else $error("unmasked port not powered");

   chk_global_off: assert property (
      @(posedge mclk_i) disable iff (!rstn_i)
      seq_hub_write(hub_status_pkg::B_GPWR_OFF) and !per_port_switch_select_i
      |=> port_power_on_flag_o == '0)
      else $error("global power off missed a port");

   chk_mask_hold: assert property (
      @(posedge mclk_i) disable iff (!rstn_i)
      per_port_switch_select_i && port_power_mask_i[1]
      && !set_port_power_i[1] && !clear_port_power_i[1]
      |=> $stable(port_power_on_flag_o[1]))
      else $error("masked port followed a global command");

   chk_mask_hold_last: assert property (
      @(posedge mclk_i) disable iff (!rstn_i)
      per_port_switch_select_i && port_power_mask_i[NPORT]
      && !set_port_power_i[NPORT] && !clear_port_power_i[NPORT]
      |=> $stable(port_power_on_flag_o[NPORT]))
      else $error("masked last port followed a global command");

   chk_resume_irq: assert property (
      @(posedge mclk_i) disable iff (!rstn_i)
      seq_resume_cause and st_q.irq_msk[hub_status_pkg::IRQ_RESUME]
      and !(wr_i && (addr_i == hub_status_pkg::CMD_IRQ_MSK_WRITE))
      |=> irq_o)
      else $error("resume interrupt not raised");
endmodule : root_hub_status_register
`default_nettype wire

// >>> hw/hub_status_pkg.sv
package hub_status_pkg;
   localparam int NPORT = 2;
   localparam logic [7:0] CMD_HUB_READ = 8'h14;
   localparam logic [7:0] CMD_HUB_WRITE = 8'h94;
   localparam logic [7:0] CMD_IRQ_ST_READ = 8'h30;
   localparam logic [7:0] CMD_IRQ_ST_WRITE = 8'hB0;
   localparam logic [7:0] CMD_IRQ_MSK_READ = 8'h31;
   localparam logic [7:0] CMD_IRQ_MSK_WRITE = 8'hB1;
   // bit positions of the hub-wide register
   localparam int B_WAKE_CLR = 31;
   localparam int B_OC_CHG = 17;
   localparam int B_LP_CHG = 16;
   localparam int B_GPWR_ON = 16;
   localparam int B_WAKE_EN = 15;
   localparam int B_OC = 1;
   localparam int B_LP = 0;
   localparam int B_GPWR_OFF = 0;
   // interrupt status and mask layout
   localparam int IRQ_RESUME = 0;
   localparam int IRQ_OC_CHG = 1;
   localparam int NIRQ = 2;
   // reset values
   localparam logic RST_WAKE_EN = 1'b0;
   localparam logic RST_OC_CHG = 1'b0;
   localparam logic [NPORT:1] RST_PWR = 2'h0;
   localparam logic [NIRQ-1:0] RST_IRQ_ST = 2'h0;
   localparam logic [NIRQ-1:0] RST_IRQ_MSK = 2'h0;
endpackage : hub_status_pkg

// >>> hw/sync_two_flop.sv
`timescale 1ns/1ps
`default_nettype none
module sync_two_flop #(
   parameter int WIDTH = 1
) (
   input wire logic mclk_i,
   input wire logic rstn_i,
   input wire logic [WIDTH-1:0] async_i,
   output logic [WIDTH-1:0] sync_o
);
   typedef struct packed {
      logic [WIDTH-1:0] s1;
      logic [WIDTH-1:0] s2;
   } sync_state_t;

   sync_state_t st_q;
   sync_state_t st_d;

   // first stage feeds only the second stage
   always_comb
   begin
      st_d = st_q;
      st_d.s1 = async_i;
      st_d.s2 = st_q.s1;
   end

   always_ff @(posedge mclk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         st_q <= '0;
      end
      else
      begin
         st_q <= st_d;
      end
   end

   assign sync_o = st_q.s2;
endmodule : sync_two_flop
`default_nettype wire

// >>> verification/root_hub_status_register_tb.sv
`timescale 1ns/1ps
`default_nettype none
module root_hub_status_register_tb;
   localparam int LIMIT = 5000;
   logic mclk_i = 1'b0;
   logic rstn_i = 1'b0;
   logic [7:0] addr_i = 8'h00;
   logic [31:0] wdata_i = 32'h0000_0000;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic overcurrent_i = 1'b0;
   logic per_port_oc_select_i = 1'b0;
   logic per_port_switch_select_i = 1'b0;
   logic [2:0] port_power_mask_i = 3'h0;
   logic [2:1] set_port_power_i = 2'h0;
   logic [2:1] clear_port_power_i = 2'h0;
   logic [2:1] port_connect_change_i = 2'h0;
   logic bus_suspended_i = 1'b0;
   logic [31:0] rdata_o;
   logic resume_request_o;
   logic [2:1] port_power_on_flag_o;
   logic remote_wakeup_enable_o;
   logic irq_o;
   int miscompares = 0;
   int cmp_count = 0;
   int seed = 31423;
   int cycles = 0;
   bit rnd = 1'b0;
   logic [7:0] wcode [4] = '{8'h94, 8'hB0, 8'hB1, 8'hA5};
   logic [7:0] rcode [4] = '{8'h14, 8'h30, 8'h31, 8'h7E};
   logic [31:0] m_rd;
   logic m_wake, m_occ, m_s1, m_s2, m_prev, m_res;
   logic [2:1] m_pwr;
   logic [1:0] m_ist, m_msk;
   logic m_irq;

   // free-running clock, 10 ns period
   always #5 mclk_i = ~mclk_i;

   root_hub_status_register #(.NPORT(2)) dut (
      .mclk_i(mclk_i), .rstn_i(rstn_i), .addr_i(addr_i),
      .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
      .overcurrent_i(overcurrent_i),
      .per_port_oc_select_i(per_port_oc_select_i),
      .per_port_switch_select_i(per_port_switch_select_i),
      .port_power_mask_i(port_power_mask_i),
      .set_port_power_i(set_port_power_i),
      .clear_port_power_i(clear_port_power_i),
      .port_connect_change_i(port_connect_change_i),
      .bus_suspended_i(bus_suspended_i),
      .resume_request_o(resume_request_o),
      .port_power_on_flag_o(port_power_on_flag_o),
      .remote_wakeup_enable_o(remote_wakeup_enable_o), .irq_o(irq_o)
   );

   // reference model, stepped on the same edges as the design
   always @(posedge mclk_i or negedge rstn_i)
   begin : mdl
      logic hub_overcurrent_flag;
      logic hub;
      logic [31:0] w;
      if (!rstn_i)
      begin
         {m_wake, m_occ, m_s1, m_s2, m_prev, m_res} = 6'h00;
         m_pwr = 2'h0;
         m_ist = 2'h0;
         m_msk = 2'h0;
         m_rd = 32'h0;
         m_irq = 1'b0;
      end
      else
      begin
         hub_overcurrent_flag = per_port_oc_select_i ? 1'b0 : m_s2;
         w = wr_i ? wdata_i : 32'h0;
         hub = wr_i && addr_i == 8'h94;
         m_rd = 32'h0;
         if (rd_i && addr_i == 8'h14)
            m_rd = {14'h0, m_occ, 1'b0, m_wake, 13'h0, hub_overcurrent_flag, 1'b0};
         if (rd_i && addr_i == 8'h30)
            m_rd = {30'h0, m_ist};
         if (rd_i && addr_i == 8'h31)
            m_rd = {30'h0, m_msk};
         m_res = m_wake && bus_suspended_i && |port_connect_change_i;
         m_ist = (m_ist & ~((wr_i && addr_i == 8'hB0) ? w[1:0] : 2'h0))
            | {hub_overcurrent_flag != m_prev, m_res};
         m_occ = (m_occ & ~(hub & w[17])) | (hub_overcurrent_flag != m_prev);
         if (wr_i && addr_i == 8'hB1)
            m_msk = w[1:0];
         for (int p = 1; p <= 2; p++)
         begin
            if (hub && (!per_port_switch_select_i || !port_power_mask_i[p]))
            begin
               if (w[0])
                  m_pwr[p] = 1'b0;
               else if (w[16])
                  m_pwr[p] = 1'b1;
            end
            if (per_port_switch_select_i && port_power_mask_i[p])
            begin
               if (set_port_power_i[p])
                  m_pwr[p] = 1'b1;
               if (clear_port_power_i[p])
                  m_pwr[p] = 1'b0;
            end
         end
         if (hub && w[31])
            m_wake = 1'b0;
         else if (hub && w[15])
            m_wake = 1'b1;
         m_prev = hub_overcurrent_flag;
         m_s2 = m_s1;
         m_s1 = overcurrent_i;
         m_irq = |(m_ist & m_msk);
      end
   end

   task check(input bit ok, input string msg);
      cmp_count++;
      if (!ok)
      begin
         miscompares++;
         $display("mismatch at %0t: %s", $time, msg);
      end
   endtask : check

   // compare every output against the model once per cycle
   always @(negedge mclk_i)
   begin
      if (rstn_i)
      begin
         check(rdata_o[15:0] === m_rd[15:0], "read low");
         check(rdata_o === m_rd, "read data");
         check(resume_request_o === m_res, "resume");
         check(port_power_on_flag_o === m_pwr, "power");
         check(remote_wakeup_enable_o === m_wake, "wake");
         check(irq_o === m_irq, "irq");
      end
   end

   // one bus cycle; side inputs are randomised when rnd is set
   task step(input logic w, input logic r, input logic [7:0] a,
      input logic [31:0] d);
      @(posedge mclk_i);
      wr_i <= w;
      rd_i <= r;
      addr_i <= a;
      wdata_i <= d;
      set_port_power_i <= rnd ? 2'($random(seed)) : 2'h0;
      clear_port_power_i <= rnd ? 2'($random(seed)) : 2'h0;
      port_connect_change_i <= rnd ? 2'($random(seed)) : 2'h0;
      if (rnd)
      begin
         port_power_mask_i <= 3'($random(seed));
         per_port_switch_select_i <= 1'($random(seed));
         bus_suspended_i <= 1'($random(seed));
         overcurrent_i <= 1'($random(seed));
         per_port_oc_select_i <= 1'($random(seed));
      end
   endtask : step

   task rand_op;
      int op;
      logic [31:0] r;
      op = $random(seed) & 7;
      r = $random(seed);
      if (op < 3)
         step(1'b1, 1'b0, wcode[r[5:4]], r & 32'h8003_8003);
      else if (op < 6)
         step(1'b0, 1'b1, rcode[r[5:4]], 32'h0);
      else
         step(1'b0, 1'b0, 8'h00, 32'h0);
   endtask : rand_op

   // move the overcurrent pin or reporting mode, then read and clear
   task oc_case(input logic pin, input logic sel);
      step(1'b0, 1'b0, 8'h00, 32'h0);
      overcurrent_i <= pin;
      per_port_oc_select_i <= sel;
      repeat (6) step(1'b0, 1'b0, 8'h00, 32'h0);
      step(1'b0, 1'b1, 8'h14, 32'h0);
      step(1'b1, 1'b0, 8'h94, 32'h0);
      step(1'b0, 1'b1, 8'h30, 32'h0);
      step(1'b1, 1'b0, 8'h94, 32'h0002_0000);
      step(1'b1, 1'b0, 8'hB0, 32'h3);
      step(1'b0, 1'b1, 8'h14, 32'h0);
   endtask : oc_case

   task tally_and_finish;
      if (miscompares == 0 && cmp_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : tally_and_finish

   // cut a hang short
   always @(posedge mclk_i)
   begin
      cycles++;
      if (cycles == LIMIT)
      begin
         miscompares++;
         tally_and_finish();
      end
   end

   initial
   begin
      repeat (10) @(posedge mclk_i);
      rstn_i <= 1'b1;
      step(1'b1, 1'b0, 8'hB1, 32'h3);
      oc_case(1'b1, 1'b0);
      oc_case(1'b1, 1'b1);
      oc_case(1'b0, 1'b1);
      oc_case(1'b0, 1'b0);
      oc_case(1'b1, 1'b0);
      oc_case(1'b0, 1'b0);
      rnd = 1'b1;
      repeat (600) rand_op();
      rnd = 1'b0;
      step(1'b0, 1'b0, 8'h00, 32'h0);
      @(posedge mclk_i);
      rstn_i <= 1'b0;
      repeat (3) @(posedge mclk_i);
      rstn_i <= 1'b1;
      rnd = 1'b1;
      repeat (200) rand_op();
      rnd = 1'b0;
      repeat (3) step(1'b0, 1'b0, 8'h00, 32'h0);
      tally_and_finish();
   end
endmodule : root_hub_status_register_tb
`default_nettype wire
